/* inc/a429_tx_control_status_regs.vh */
`ifndef A429_TX_CONTROL_STATUS_REGS_VH
`define A429_TX_CONTROL_STATUS_REGS_VH

// Command op-codes
`define OP_TX_CTRL_WR 8'h08
`define OP_TX_CTRL_RD 8'h84
`define OP_RX1_STATUS_RD 8'h90
`define OP_RX2_STATUS_RD 8'hb0
`define OP_TX_STATUS_RD 8'h80
`define OP_DIV_WR 8'h38
`define OP_DIV_RD 8'hd4
`define OP_TX_ENABLE 8'h40
`define OP_SOFT_RESET 8'h44
`define OP_READ_BIT 7

// Transmit control fields
`define TXC_DRIVER_TRISTATE 7
`define TXC_LABEL_REVERSE 6
`define TXC_AUTO_SEND 5
`define TXC_LOOPBACK_TEST 4
`define TXC_PARITY_SENSE 3
`define TXC_PARITY_INSERT 2
`define TXC_RATE 0
`define TXC_RESET 8'h00

// Divider register fields
`define DIV_MSB 4
`define DIV_LSB 1
`define DIV_RESET 8'h00

// Status fields
`define ST_EMPTY 0
`define ST_HALF 1
`define ST_FULL 2
`define ST_PRIO_LSB 3
`define ST_PRIO_MSB 5

// FIFO occupancy
`define FIFO_DEPTH 6'd32
`define FIFO_HALF 6'd16
`define FIFO_CNT_W 6

`endif

/* hdl/fifo_occupancy.v */
`timescale 1ns/1ps
`default_nettype none
`include "a429_tx_control_status_regs.vh"

module fifo_occupancy (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_flush,
    input wire i_push,
    input wire i_pop,
    output wire o_empty,
    output wire o_half,
    output wire o_full
);

reg [`FIFO_CNT_W-1:0] count_r;
reg [`FIFO_CNT_W-1:0] count_nxt;
wire push_ok;
wire pop_ok;

// Overflow and underflow attempts are dropped so the count stays honest
assign push_ok = i_push && (count_r != `FIFO_DEPTH);
assign pop_ok = i_pop && (count_r != {`FIFO_CNT_W{1'b0}});

always @* begin
    count_nxt = count_r;
    if (i_flush) begin
        count_nxt = {`FIFO_CNT_W{1'b0}};
    end else if (push_ok && !pop_ok) begin
        count_nxt = count_r + 6'd1;
    end else if (pop_ok && !push_ok) begin
        count_nxt = count_r - 6'd1;
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        count_r <= {`FIFO_CNT_W{1'b0}};
    end else if (i_ce) begin
        count_r <= count_nxt;
    end
end

// Flags follow the count directly, one cycle after each push or pop
assign o_full = (count_r == `FIFO_DEPTH);
assign o_half = (count_r >= `FIFO_HALF);
assign o_empty = (count_r == {`FIFO_CNT_W{1'b0}});

endmodule
`default_nettype wire

/* hdl/a429_tx_control_status_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "a429_tx_control_status_regs.vh"

module a429_tx_control_status_regs (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_cmd_valid,
    input wire [7:0] i_cmd_op,
    input wire [7:0] i_cmd_wdata,
    output reg o_rd_valid,
    output reg [7:0] o_rd_data,
    input wire [1:0] i_rx_push,
    input wire [1:0] i_rx_pop,
    input wire i_tx_push,
    input wire i_tx_pop,
    input wire [5:0] i_prio_hit,
    input wire [5:0] i_prio_read,
    input wire [31:0] i_tx_word,
    input wire i_tx_busy,
    input wire i_tx_line_a,
    input wire i_tx_line_b,
    input wire i_rx1_line_a,
    input wire i_rx1_line_b,
    input wire i_rx2_line_a,
    input wire i_rx2_line_b,
    output reg [31:0] o_tx_word,
    output reg o_tx_go,
    output reg o_tx_low_rate,
    output reg [3:0] o_ref_div,
    output reg o_fifo_flush,
    output reg o_line_a,
    output reg o_line_b,
    output reg o_line_a_oe_n,
    output reg o_line_b_oe_n,
    output reg o_rx1_a,
    output reg o_rx1_b,
    output reg o_rx2_a,
    output reg o_rx2_b
);

reg [7:0] tx_ctrl_r;
reg [7:0] div_r;
reg send_armed_r;
reg send_armed_nxt;
reg [5:0] prio_r;
reg [5:0] prio_nxt;
reg [7:0] rd_nxt;
reg [31:0] word_nxt;

wire driver_tristate;
wire tx_label_reverse;
wire tx_auto_send;
wire loopback_test;
wire parity_sense;
wire tx_parity_insert;
wire is_read;
wire op_tx_ctrl_wr;
wire op_div_wr;
wire op_tx_enable;
wire op_soft_reset;
wire [2:0] fifo_push;
wire [2:0] fifo_pop;
wire [2:0] fifo_empty;
wire [2:0] fifo_half;
wire [2:0] fifo_full;
wire [7:0] rx1_status;
wire [7:0] rx2_status;
wire [7:0] tx_status;
wire body_parity;
wire tx_fifo_empty;
wire [15:0] rx_status;
wire [7:0] label_mirror;
wire send_ok;

assign driver_tristate = tx_ctrl_r[`TXC_DRIVER_TRISTATE];
assign tx_label_reverse = tx_ctrl_r[`TXC_LABEL_REVERSE];
assign tx_auto_send = tx_ctrl_r[`TXC_AUTO_SEND];
assign loopback_test = tx_ctrl_r[`TXC_LOOPBACK_TEST];
assign parity_sense = tx_ctrl_r[`TXC_PARITY_SENSE];
assign tx_parity_insert = tx_ctrl_r[`TXC_PARITY_INSERT];

assign is_read = i_cmd_valid && i_cmd_op[`OP_READ_BIT];
assign op_tx_ctrl_wr = i_cmd_valid && (i_cmd_op == `OP_TX_CTRL_WR);
assign op_div_wr = i_cmd_valid && (i_cmd_op == `OP_DIV_WR);
assign op_tx_enable = i_cmd_valid && (i_cmd_op == `OP_TX_ENABLE);
assign op_soft_reset = i_cmd_valid && (i_cmd_op == `OP_SOFT_RESET);

// Channel 0 and 1 are the receivers, channel 2 the transmitter
assign fifo_push = {i_tx_push, i_rx_push};
assign fifo_pop = {i_tx_pop, i_rx_pop};

genvar ch;
genvar lbit;
generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_occ
        fifo_occupancy u_occ (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_ce(i_ce),
            .i_flush(op_soft_reset),
            .i_push(fifo_push[ch]),
            .i_pop(fifo_pop[ch]),
            .o_empty(fifo_empty[ch]),
            .o_half(fifo_half[ch]),
            .o_full(fifo_full[ch])
        );
    end
endgenerate

assign tx_fifo_empty = fifo_empty[2];

// Each receiver sees only its own FIFO and mailbox hits
generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_rx_status
        assign rx_status[8*ch+7:8*ch] = {2'h0, prio_r[3*ch+2:3*ch], fifo_full[ch], fifo_half[ch],
                                         fifo_empty[ch]};
    end
endgenerate

assign rx1_status = rx_status[7:0];
assign rx2_status = rx_status[15:8];
assign tx_status = {5'h00, fifo_full[2], fifo_half[2], fifo_empty[2]};

// Mailbox hit flags: a new hit beats a same-cycle read or flush
always @* begin
    prio_nxt = prio_r & ~i_prio_read;
    if (op_soft_reset) begin
        prio_nxt = 6'h00;
    end
    prio_nxt = prio_nxt | i_prio_hit;
end

// Enable command arms sending until the queue drains
always @* begin
    send_armed_nxt = send_armed_r;
    if (tx_fifo_empty && !i_tx_busy) begin
        send_armed_nxt = 1'b0;
    end
    if (op_soft_reset) begin
        send_armed_nxt = 1'b0;
    end
    if (op_tx_enable) begin
        send_armed_nxt = 1'b1;
    end
end

// Soft reset drops send permission at once, on the same edge that clears the counts
assign send_ok = !tx_fifo_empty && !op_soft_reset && (tx_auto_send || send_armed_r);

// Unknown read op-codes answer zero so the host never stalls
always @* begin
    case (i_cmd_op)
        `OP_TX_CTRL_RD: rd_nxt = tx_ctrl_r;
        `OP_RX1_STATUS_RD: rd_nxt = rx1_status;
        `OP_RX2_STATUS_RD: rd_nxt = rx2_status;
        `OP_TX_STATUS_RD: rd_nxt = tx_status;
        `OP_DIV_RD: rd_nxt = div_r;
        default: rd_nxt = 8'h00;
    endcase
end

// Label byte mirrored bit by bit for the reversal option
generate
    for (lbit = 0; lbit < 8; lbit = lbit + 1) begin : g_label_mirror
        assign label_mirror[lbit] = i_tx_word[7-lbit];
    end
endgenerate

// Parity over the 31 lower bits; mirroring the label cannot change it
assign body_parity = ^i_tx_word[30:0];

always @* begin
    word_nxt = i_tx_word;
    if (tx_label_reverse) begin
        word_nxt[7:0] = label_mirror;
    end
    // Odd sense makes the total count of ones odd
    if (tx_parity_insert) begin
        word_nxt[31] = parity_sense ? body_parity : ~body_parity;
    end else begin
        word_nxt[31] = i_tx_word[31];
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        tx_ctrl_r <= `TXC_RESET;
        div_r <= `DIV_RESET;
        send_armed_r <= 1'b0;
        prio_r <= 6'h00;
        o_rd_valid <= 1'b0;
        o_rd_data <= 8'h00;
        o_fifo_flush <= 1'b0;
    end else if (i_ce) begin
        // Soft reset leaves the writable registers alone
        if (op_tx_ctrl_wr) begin
            tx_ctrl_r <= i_cmd_wdata;
        end
        if (op_div_wr) begin
            div_r <= i_cmd_wdata;
        end
        send_armed_r <= send_armed_nxt;
        prio_r <= prio_nxt;
        o_rd_valid <= is_read;
        // Last answer stays put so a slow host can still collect it
        if (is_read) begin
            o_rd_data <= rd_nxt;
        end
        o_fifo_flush <= op_soft_reset;
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_tx_word <= 32'h00000000;
        o_tx_go <= 1'b0;
        o_tx_low_rate <= 1'b0;
        o_ref_div <= 4'h0;
    end else if (i_ce) begin
        o_tx_word <= word_nxt;
        o_tx_go <= send_ok;
        o_tx_low_rate <= tx_ctrl_r[`TXC_RATE];
        // Spare divider bits are kept for readback only
        o_ref_div <= div_r[`DIV_MSB:`DIV_LSB];
    end
end

// Tristate outranks the loopback NULL hold
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_line_a <= 1'b0;
        o_line_b <= 1'b0;
        // Driver stays floated until the first enabled clock
        o_line_a_oe_n <= 1'b1;
        o_line_b_oe_n <= 1'b1;
    end else if (i_ce) begin
        o_line_a_oe_n <= driver_tristate;
        o_line_b_oe_n <= driver_tristate;
        if (loopback_test) begin
            o_line_a <= 1'b0;
            o_line_b <= 1'b0;
        end else begin
            o_line_a <= i_tx_line_a;
            o_line_b <= i_tx_line_b;
        end
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_rx1_a <= 1'b0;
        o_rx1_b <= 1'b0;
        o_rx2_a <= 1'b0;
        o_rx2_b <= 1'b0;
    end else if (i_ce) begin
        // External receive levels are dropped entirely while looped back
        if (loopback_test) begin
            o_rx1_a <= i_tx_line_a;
            o_rx1_b <= i_tx_line_b;
            o_rx2_a <= i_tx_line_a;
            o_rx2_b <= i_tx_line_b;
        end else begin
            o_rx1_a <= i_rx1_line_a;
            o_rx1_b <= i_rx1_line_b;
            o_rx2_a <= i_rx2_line_a;
            o_rx2_b <= i_rx2_line_b;
        end
    end
end

endmodule
`default_nettype wire

/* verification/a429_regs_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module a429_regs_chk (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_cmd_valid,
    input wire [7:0] i_cmd_op,
    input wire [7:0] i_cmd_wdata,
    input wire i_tx_line_a,
    input wire o_rd_valid,
    input wire o_tx_go,
    input wire o_fifo_flush,
    input wire o_line_a,
    input wire o_line_b,
    input wire o_line_a_oe_n,
    input wire o_line_b_oe_n,
    input wire o_rx1_a,
    input wire o_rx2_a
);
    logic [7:0] ctl_r;
    wire take = i_ce && i_cmd_valid;
    // Shadow of the control byte, so line checks need no internal probe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            ctl_r <= 8'h00;
        else if (take && i_cmd_op == 8'h08)
            ctl_r <= i_cmd_wdata;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    rd_answer_a: assert property (take && i_cmd_op[7] |=> o_rd_valid)
        else $error("read not answered");
    rd_quiet_a: assert property (i_ce && !(take && i_cmd_op[7]) |=> !o_rd_valid)
        else $error("stray read answer");
    flush_pulse_a: assert property (take && i_cmd_op == 8'h44 |=> o_fifo_flush)
        else $error("no flush after soft reset");
    soft_go_a: assert property (take && i_cmd_op == 8'h44 |-> ##2 !o_tx_go)
        else $error("transmit still enabled after soft reset");
    oe_pair_a: assert property (o_line_a_oe_n == o_line_b_oe_n)
        else $error("driver enables differ");
    oe_track_a: assert property ($past(i_nrst) && $past(i_ce) |-> o_line_a_oe_n == $past(ctl_r[7]))
        else $error("driver enable does not follow control");
    loop_null_a: assert property ($past(i_nrst) && $past(i_ce) && $past(ctl_r[4]) |-> !o_line_a && !o_line_b)
        else $error("lines not null in loopback");
    loop_route_a: assert property ($past(i_nrst) && $past(i_ce) && $past(ctl_r[4])
        |-> o_rx1_a == $past(i_tx_line_a) && o_rx2_a == $past(i_tx_line_a))
        else $error("loopback path wrong");
endmodule
bind a429_tx_control_status_regs a429_regs_chk a429_regs_chk_i (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op),
    .i_cmd_wdata(i_cmd_wdata),
    .i_tx_line_a(i_tx_line_a),
    .o_rd_valid(o_rd_valid),
    .o_tx_go(o_tx_go),
    .o_fifo_flush(o_fifo_flush),
    .o_line_a(o_line_a),
    .o_line_b(o_line_b),
    .o_line_a_oe_n(o_line_a_oe_n),
    .o_line_b_oe_n(o_line_b_oe_n),
    .o_rx1_a(o_rx1_a),
    .o_rx2_a(o_rx2_a)
);
`default_nettype wire

/* verification/a429_host.sv */
`timescale 1ns/1ps
`default_nettype none
module a429_host (
    input wire logic i_clk,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    output logic o_cmd_valid = 1'b0,
    output logic [7:0] o_cmd_op = 8'hff,
    output logic [7:0] o_cmd_wdata = 8'h00
);
    // One op per call, held only for its taking edge
    task automatic xfer(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_op <= op;
        o_cmd_wdata <= wd;
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_op <= ~op;
        o_cmd_wdata <= ~wd;
        @(negedge i_clk);
        rd = i_rd_valid ? i_rd_data : 8'hxx;
    endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic cv, rv, go, low, fl, la, lb, oa, ob, r1a, r1b, r2a, r2b;
    logic [7:0] op, wd, rdat;
    logic [3:0] dv;
    logic [31:0] tw;
    logic [17:0] ev = 18'h0;
    logic [5:0] ln = 6'h0;
    int fails = 0;
    int compares = 0;
    int flushes = 0;
    always #4 i_clk = ~i_clk;
    // One count per clock the flush stands, so a stretched pulse shows up
    always @(posedge i_clk) begin
        if (fl) begin
            flushes++;
        end
    end
    a429_host a429_host_i (.i_clk(i_clk), .i_rd_valid(rv), .i_rd_data(rdat), .o_cmd_valid(cv),
        .o_cmd_op(op), .o_cmd_wdata(wd));
    a429_tx_control_status_regs a429_tx_control_status_regs_i (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_ce(i_ce), .i_cmd_valid(cv), .i_cmd_op(op), .i_cmd_wdata(wd), .o_rd_valid(rv),
        .o_rd_data(rdat), .i_rx_push(ev[17:16]), .i_rx_pop(ev[15:14]), .i_tx_push(ev[13]),
        .i_tx_pop(ev[12]), .i_prio_hit(ev[11:6]), .i_prio_read(ev[5:0]), .i_tx_word(32'h80000003),
        .i_tx_busy(1'b0), .i_tx_line_a(ln[5]), .i_tx_line_b(ln[4]), .i_rx1_line_a(ln[3]),
        .i_rx1_line_b(ln[2]), .i_rx2_line_a(ln[1]), .i_rx2_line_b(ln[0]), .o_tx_word(tw),
        .o_tx_go(go), .o_tx_low_rate(low), .o_ref_div(dv), .o_fifo_flush(fl), .o_line_a(la),
        .o_line_b(lb), .o_line_a_oe_n(oa), .o_line_b_oe_n(ob), .o_rx1_a(r1a), .o_rx1_b(r1b),
        .o_rx2_a(r2a), .o_rx2_b(r2b));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task rd(input logic [7:0] o, input logic [7:0] exp);
        logic [7:0] v;
        a429_host_i.xfer(o, 8'h00, v);
        chk(v, exp, "read");
    endtask
    task wr(input logic [7:0] o, input logic [7:0] d);
        logic [7:0] v;
        a429_host_i.xfer(o, d, v);
        repeat (2) @(negedge i_clk);
    endtask
    // Event bits: rx push, rx pop, tx push, tx pop, mailbox hit, mailbox read
    task pulse(input logic [17:0] v, input int n);
        @(posedge i_clk);
        ev <= v;
        repeat (n) @(posedge i_clk);
        ev <= 18'h0;
    endtask
    task t_reset;
        rd(8'h90, 8'h01);
        rd(8'hb0, 8'h01);
        rd(8'h80, 8'h01);
        rd(8'h84, 8'h00);
        rd(8'hfc, 8'h00);
        chk(low, 1'b0, "low rate");
        chk({oa, ob}, 2'b00, "driver on");
    endtask
    task t_regs;
        wr(8'h08, 8'h03);
        rd(8'h84, 8'h03);
        chk(low, 1'b1, "low rate");
        wr(8'h38, 8'h1e);
        rd(8'hd4, 8'h1e);
        chk(dv, 4'hf, "divider");
        @(posedge i_clk) i_ce <= 1'b0;
        wr(8'h08, 8'hff);
        @(posedge i_clk) i_ce <= 1'b1;
        rd(8'h84, 8'h03);
        wr(8'h08, 8'h02);
    endtask
    task t_fifo;
        pulse(18'h02000, 15);
        rd(8'h80, 8'h00);
        pulse(18'h02000, 1);
        rd(8'h80, 8'h02);
        pulse(18'h02000, 17);
        rd(8'h80, 8'h06);
        pulse(18'h01000, 1);
        rd(8'h80, 8'h02);
        chk(go, 1'b0, "held");
        pulse(18'h10000, 32);
        pulse(18'h001c0, 1);
        rd(8'h90, 8'h3e);
        rd(8'hb0, 8'h01);
        pulse(18'h04000, 16);
        pulse(18'h00002, 1);
        rd(8'h90, 8'h2a);
        pulse(18'h20200, 1);
        rd(8'hb0, 8'h08);
        wr(8'h44, 8'h00);
        chk(flushes, 1, "flush pulses");
        rd(8'h90, 8'h01);
        rd(8'hb0, 8'h01);
        rd(8'h80, 8'h01);
        rd(8'h84, 8'h02);
    endtask
    task t_tx;
        logic [7:0] cw [4] = '{8'h00, 8'h40, 8'h44, 8'h0c};
        logic [31:0] ew [4] = '{32'h80000003, 32'h800000c0, 32'h800000c0, 32'h00000003};
        pulse(18'h02000, 1);
        repeat (3) @(negedge i_clk);
        chk(go, 1'b0, "go");
        wr(8'h40, 8'h00);
        chk(go, 1'b1, "go");
        pulse(18'h01000, 1);
        wr(8'h08, 8'h20);
        pulse(18'h02000, 1);
        repeat (3) @(negedge i_clk);
        chk(go, 1'b1, "go");
        pulse(18'h01000, 1);
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, cw[k]);
            chk(tw, ew[k], "tx word");
        end
    endtask
    task t_line;
        wr(8'h08, 8'h80);
        chk({oa, ob}, 2'b11, "hiz");
        @(posedge i_clk) ln <= 6'b100101;
        wr(8'h08, 8'h10);
        chk({la, lb, oa, r1a, r1b, r2a, r2b}, 7'b0001010, "loop");
        wr(8'h08, 8'h00);
    endtask
    task conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_reset;
        t_regs;
        t_fifo;
        t_tx;
        t_line;
        conclude;
    end
    initial begin
        #200000;
        fails++;
        conclude;
    end
endmodule
`default_nettype wire
